// file: logic/dbc_defs.svh
// Constants and register map of the dynamic brake chopper controller
// Function
// - Action 1: warning 104 when remaining capacity reaches 25 percent.
// - Action 2: warn at 25 percent, trip 67 at 0 percent.
// - Action 3: regen limit cut to average power, plus warn and trip.
// - Healthy flag set while no overload warning or trip.
// - Proportional bridge braking makes action 3 behave as action 2.
// - Remaining capacity readable, 0 to 100 percent.
// - Brake works only when enabled; default source is output enabled.
// - Thermostat forces capacity to 0 and disables brake.
// - Source 1 internal, 2 analogue one, 3 analogue two.
// - Internal link voltage and comparator updated every PWM period.
// - Percent sources scaled by volts-at-100-percent, limited to 2000 V.
// - Mode 0 threshold once per period, mode 1 proportional.
// - Proportional mode: PWM duty follows modulation demand.
// - Demand clamped to modulation ceiling even above threshold.
// - Ramp runs every 5 ms scan; up to 5 ms is a step.
// - Ramped demand resets to zero while brake disabled.
// - Route selects port or bridge; bridge with a nonzero motor control method raises warning 138.
// - Bridge braking uses three phases offset by a third period.
// - External unit permits regen and disables resistor monitoring.
// - Current and power per resistor calculated, clamped to range.
// - Internal unit seen only if mains power-up or strap set.
// - Threshold mode switches fully on above voltage threshold.
// - Route 0 drives the dedicated brake port.
`ifndef DBC_DEFS_SVH
`define DBC_DEFS_SVH
`define DBC_CLK_NS 5
`define DBC_SCAN_NS 5000000
`define DBC_SCAN_CYCLES (`DBC_SCAN_NS / `DBC_CLK_NS)
`define DBC_PWM_CYCLES 80000
`define DBC_SCAN_MS 16'h0005
`define DBC_RAMP_NUM 16'h1388
`define DBC_FULL_MOD 11'h3E8
`define DBC_VMAX 16'sh07D0
`define DBC_IMAX 32'h0000_4E20
`define DBC_PMAX 32'h0000_7530
`define DBC_WARN_PCT 7'h19
`define DBC_FULL_PCT 7'h64
`define DBC_BOOT_CAP 3'h4
`define DBC_BOOT_END 3'h5
`define DBC_CODE_WARN 8'h68
`define DBC_CODE_TRIP 8'h43
`define DBC_CODE_ROUTE 8'h8A
`define DBC_REG_CTRL 8'h00
`define DBC_REG_THRESH 8'h04
`define DBC_REG_SCALE 8'h08
`define DBC_REG_CEIL 8'h0C
`define DBC_REG_RAMP 8'h10
`define DBC_REG_RES 8'h14
`define DBC_REG_AVGP 8'h18
`define DBC_REG_BUDGET 8'h1C
`define DBC_REG_REGEN 8'h20
`define DBC_REG_STATUS 8'h24
`define DBC_REG_DEMAND 8'h28
`define DBC_REG_VDC 8'h2C
`define DBC_REG_CURR 8'h30
`define DBC_REG_POWER 8'h34
`define DBC_CTRL_RST 8'h05
`define DBC_THRESH_RST 16'h02EE
`define DBC_SCALE_RST 16'h03E8
`define DBC_RES_RST 16'h0064
`define DBC_AVGP_RST 16'h0064
`define DBC_BUDGET_RST 32'h0001_86A0
`define DBC_REGEN_RST 16'hFFFF
`endif

// file: logic/dbc_pkg.sv
// Types of the dynamic brake chopper controller
package dbc_pkg;
   typedef enum logic [1:0] {
      DBC_SRC_NONE = 2'b00,
      DBC_SRC_INT = 2'b01,
      DBC_SRC_AIN1 = 2'b10,
      DBC_SRC_AIN2 = 2'b11
   } dbc_src_t;
   typedef enum logic [1:0] {
      DBC_ACT_NONE = 2'b00,
      DBC_ACT_WARN = 2'b01,
      DBC_ACT_TRIP = 2'b10,
      DBC_ACT_LIMIT = 2'b11
   } dbc_action_t;
   typedef struct packed {
      logic en_src;
      logic ext_unit;
      logic route;
      logic mode;
      dbc_src_t src;
      dbc_action_t action;
   } dbc_ctrl_t;
   typedef struct packed {
      logic unit_strap;
      logic mains_powerup;
      logic thermostat;
      logic brake_enable;
      logic output_enabled;
   } dbc_pins_t;
endpackage : dbc_pkg

// file: logic/dbc_brake.sv
// Dynamic brake chopper controller
`timescale 1ns/10ps
`default_nettype none
`include "dbc_defs.svh"
module dbc_brake #(
   parameter int unsigned SCAN_CYCLES = `DBC_SCAN_CYCLES,
   parameter int unsigned PWM_CYCLES = `DBC_PWM_CYCLES,
   parameter logic [3:0] DB_METHOD = 4'h1
) (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic ce,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Pins and measurements
   input wire dbc_pkg::dbc_pins_t pins,
   input wire logic signed [15:0] vdc_internal,
   input wire logic signed [15:0] analog_in1,
   input wire logic signed [15:0] analog_in2,
   input wire logic [10:0] mod_ref,
   input wire logic [3:0] motor_control_method,
   // Outputs
   output logic brake_port_gate,
   output logic [2:0] bridge_gate,
   output logic [7:0] warn_code,
   output logic [7:0] trip_code,
   output logic resistor_healthy_flag,
   output logic signed [15:0] regen_limit,
   output logic regen_permitted
);
   localparam int PW = $clog2(PWM_CYCLES);
   localparam int SW = $clog2(SCAN_CYCLES);
   localparam logic [PW-1:0] PTOP = PW'(PWM_CYCLES - 1);
   localparam logic [SW-1:0] STOP = SW'(SCAN_CYCLES - 1);

   // ------------------------------------------------
   // Helper functions
   // ------------------------------------------------
   // Percent source to volts, clamped to the legal range
   function automatic logic signed [15:0] to_volts(input logic signed [15:0] pct,
                                                  input logic signed [15:0] sc);
      logic signed [31:0] p;
      // 32768 is full scale: drop 15 bits
      p = (pct * sc) >>> 15;
      if (p > 32'(`DBC_VMAX)) to_volts = `DBC_VMAX;
      else if (p < -32'(`DBC_VMAX)) to_volts = -`DBC_VMAX;
      else to_volts = p[15:0];
   endfunction : to_volts

   // Integer square root
   function automatic logic [15:0] isqrt(input logic [31:0] x);
      logic [15:0] r;
      // Bit by bit from the top, no divider
      r = 16'h0000;
      for (int i = 15; i >= 0; i--) begin
         if (32'(r | (16'h0001 << i)) * 32'(r | (16'h0001 << i)) <= x) r = r | (16'h0001 << i);
      end
      isqrt = r;
   endfunction : isqrt

   // ------------------------------------------------
   // Registers and pin capture
   // ------------------------------------------------
   dbc_pkg::dbc_ctrl_t ctrl;
   logic [15:0] thresh, ramp_ms, res, avgp;
   logic signed [15:0] scale, regen_reg;
   logic [10:0] ceil_mod;
   logic [31:0] budget;
   logic [4:0] s1, s2, s3;
   dbc_pkg::dbc_pins_t pq;
   logic [2:0] boot_cnt;
   logic unit_seen;

   // Three stage synchroniser, a change accepted once stages agree
   // A one-cycle glitch never reaches the logic
   // Filter reads stages two and three only
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s1 <= 5'h00;
         s2 <= 5'h00;
         s3 <= 5'h00;
         pq <= '0;
      end else if (ce) begin
         s1 <= pins;
         s2 <= s1;
         s3 <= s2;
         pq <= (s3 & ~(s2 ^ s3)) | (pq & (s2 ^ s3));
      end
   end

   // Internal unit presence caught once pins have settled
   // Filter holds the straps from the fourth edge on;
   // an earlier look sees reset values and loses the unit
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         boot_cnt <= 3'h0;
         unit_seen <= 1'b0;
      end else if (ce && boot_cnt != `DBC_BOOT_END) begin
         boot_cnt <= boot_cnt + 3'h1;
         if (boot_cnt == `DBC_BOOT_CAP) unit_seen <= pq.mains_powerup | pq.unit_strap;
      end
   end

   // Software writes
   // Narrow fields take the low data bits
   // Unmapped offsets are ignored
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl <= `DBC_CTRL_RST;
         thresh <= `DBC_THRESH_RST;
         scale <= `DBC_SCALE_RST;
         ceil_mod <= `DBC_FULL_MOD;
         ramp_ms <= 16'h0000;
         res <= `DBC_RES_RST;
         avgp <= `DBC_AVGP_RST;
         budget <= `DBC_BUDGET_RST;
         regen_reg <= `DBC_REGEN_RST;
      end else if (ce && reg_wr) begin
         case (reg_addr)
            `DBC_REG_CTRL: ctrl <= reg_wdata[7:0];
            `DBC_REG_THRESH: thresh <= reg_wdata[15:0];
            `DBC_REG_SCALE: scale <= reg_wdata[15:0];
            `DBC_REG_CEIL: ceil_mod <= reg_wdata[10:0];
            `DBC_REG_RAMP: ramp_ms <= reg_wdata[15:0];
            `DBC_REG_RES: res <= reg_wdata[15:0];
            `DBC_REG_AVGP: avgp <= reg_wdata[15:0];
            `DBC_REG_BUDGET: budget <= reg_wdata;
            `DBC_REG_REGEN: regen_reg <= reg_wdata[15:0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------
   // Timing, enable and voltage
   // ------------------------------------------------
   logic [PW-1:0] pwm_cnt;
   logic [SW-1:0] scan_cnt;
   logic pwm_start, scan_tick, en_flag, active, bridge_ok, route_warn;
   logic signed [15:0] vdc_sel, vdc_q;

   // PWM period and 5 ms scan counters
   // Free running, settings never move the edges
   // First decision one period after release
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pwm_cnt <= '0;
         scan_cnt <= '0;
      end else if (ce) begin
         pwm_cnt <= (pwm_cnt == PTOP) ? '0 : pwm_cnt + 1'b1;
         scan_cnt <= (scan_cnt == STOP) ? '0 : scan_cnt + 1'b1;
      end
   end
   assign pwm_start = (pwm_cnt == PTOP);
   assign scan_tick = (scan_cnt == STOP);

   // Enable path and routing checks
   // Without a seen unit the brake stays off
   // Route warning tells that the bridge route is set with a nonzero motor control method
   assign en_flag = ctrl.en_src ? pq.brake_enable : pq.output_enabled;
   assign active = en_flag & ~pq.thermostat & unit_seen;
   assign bridge_ok = ctrl.route & ctrl.mode & (motor_control_method == DB_METHOD);
   assign route_warn = ctrl.route & (motor_control_method != 4'h0);

   // Comparator input selection
   // Unknown codes fall back to the internal value
   always_comb begin
      case (ctrl.src)
         dbc_pkg::DBC_SRC_AIN1: vdc_sel = to_volts(analog_in1, scale);
         dbc_pkg::DBC_SRC_AIN2: vdc_sel = to_volts(analog_in2, scale);
         default: vdc_sel = vdc_internal;
      endcase
   end

   // ------------------------------------------------
   // Demand, ramp and switching
   // ------------------------------------------------
   logic thr_on;
   logic [10:0] demand, target, step;
   logic [PW-1:0] duty_cnt;
   logic [47:0] duty_full;
   logic [PW-1:0] phase [3];
   logic [10:0] duty_mod;

   // Link voltage sample and threshold decision once per period
   // Duty latched here so no pulse is cut short
   // Threshold result holds for a whole period
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         vdc_q <= 16'sh0000;
         thr_on <= 1'b0;
         duty_cnt <= '0;
      end else if (ce && pwm_start) begin
         vdc_q <= vdc_sel;
         thr_on <= active & (vdc_sel > $signed({1'b0, thresh[14:0]}));
         duty_cnt <= duty_full[PW-1:0];
      end
   end

   // Ceiling clamp and ramp step
   // Demand stays below 1001, demand plus step fits
   // Ramp times up to one scan give a full step
   always_comb begin
      target = (mod_ref < ceil_mod) ? mod_ref : ceil_mod;
      if (target > `DBC_FULL_MOD) target = `DBC_FULL_MOD;
      if (ramp_ms <= `DBC_SCAN_MS) step = `DBC_FULL_MOD;
      else step = 11'(`DBC_RAMP_NUM / ramp_ms);
      duty_full = (48'(demand) * 48'(PWM_CYCLES)) / 48'(`DBC_FULL_MOD);
   end

   // Ramped demand, cleared while disabled
   // Ramp restarts from zero on the next enable
   // Last step lands exactly on target
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         demand <= 11'h000;
      end else if (ce) begin
         if (!active) demand <= 11'h000;
         else if (scan_tick) begin
            if (target > demand) demand <= (target - demand > step) ? demand + step : target;
            else demand <= (demand - target > step) ? demand - step : target;
         end
      end
   end

   // ------------------------------------------------
   // Bridge phases and gates
   // ------------------------------------------------
   // Three phases a third of a period apart
   // Same duty on each phase: triple ripple rate
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_phase
         logic [PW:0] sum;
         assign sum = (PW+1)'(pwm_cnt) + (PW+1)'(g * (PWM_CYCLES / 3));
         assign phase[g] = (sum >= (PW+1)'(PWM_CYCLES)) ?
                           PW'(sum - (PW+1)'(PWM_CYCLES)) : sum[PW-1:0];
      end
   endgenerate

   // Gate outputs
   // Route bit chooses port or bridge, never both
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         brake_port_gate <= 1'b0;
         bridge_gate <= 3'h0;
      end else if (ce) begin
         brake_port_gate <= active & ~ctrl.route &
                            (ctrl.mode ? (pwm_cnt < duty_cnt) : thr_on);
         for (int k = 0; k < 3; k++)
            bridge_gate[k] <= active & bridge_ok & (phase[k] < duty_cnt);
      end
   end

   // ------------------------------------------------
   // Resistor model and overload
   // ------------------------------------------------
   logic [15:0] vpos, res_nz;
   logic [47:0] p_w, i_sq;
   logic [31:0] p_01, i_01, used, next_used;
   logic [6:0] remaining;
   logic warn, trip, lim_on;

   // Calculated power and current per resistor
   // Volts, tenth ohms, tenth percent; power in watts
   // Zero resistance reads as the smallest step
   always_comb begin
      vpos = vdc_q[15] ? 16'h0000 : vdc_q;
      res_nz = (res == 16'h0000) ? 16'h0001 : res;
      duty_mod = ctrl.mode ? demand : (thr_on ? `DBC_FULL_MOD : 11'h000);
      if (!(brake_port_gate | (|bridge_gate)) && !thr_on) duty_mod = 11'h000;
      p_w = (48'(vpos) * 48'(vpos) * 48'(duty_mod)) / (48'(res_nz) * 48'h64);
      p_01 = (p_w / 48'h64 > 48'(`DBC_PMAX)) ? `DBC_PMAX : 32'(p_w / 48'h64);
      i_sq = (p_w * 48'h3E8) / 48'(res_nz);
      i_01 = (i_sq > 48'hFFFF_FFFF) ? `DBC_IMAX : 32'(isqrt(i_sq[31:0]));
      if (i_01 > `DBC_IMAX) i_01 = `DBC_IMAX;
      if (used + p_01 <= 32'(avgp)) next_used = 32'h0;
      else next_used = used + p_01 - 32'(avgp);
      if (next_used > budget) next_used = budget;
   end

   // Energy use and remaining capacity each scan
   // Zero budget means no monitoring: reads full
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         used <= 32'h0;
         remaining <= `DBC_FULL_PCT;
      end else if (ce) begin
         if (scan_tick) used <= next_used;
         if (pq.thermostat) remaining <= 7'h00;
         else if (budget == 32'h0) remaining <= `DBC_FULL_PCT;
         else remaining <= `DBC_FULL_PCT -
                           7'((64'(used) * 64'h64) / 64'(budget));
      end
   end

   // Overload action decode
   // Levels follow capacity, nothing is latched
   // External unit takes monitoring away
   always_comb begin
      warn = (ctrl.action != dbc_pkg::DBC_ACT_NONE) &
             (remaining <= `DBC_WARN_PCT) & ~ctrl.ext_unit;
      trip = ((ctrl.action == dbc_pkg::DBC_ACT_TRIP) |
              (ctrl.action == dbc_pkg::DBC_ACT_LIMIT)) &
             (remaining == 7'h00) & ~ctrl.ext_unit;
      lim_on = (ctrl.action == dbc_pkg::DBC_ACT_LIMIT) & ~ctrl.ext_unit &
               ~(ctrl.mode & bridge_ok);
   end

   // ------------------------------------------------
   // Status outputs
   // ------------------------------------------------
   // Flags, codes and regen limit
   // Register value -1 means no limit at all
   // Average power replaces only a larger limit
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         warn_code <= 8'h00;
         trip_code <= 8'h00;
         resistor_healthy_flag <= 1'b1;
         regen_limit <= `DBC_REGEN_RST;
         regen_permitted <= 1'b0;
      end else if (ce) begin
         warn_code <= warn ? `DBC_CODE_WARN : (route_warn ? `DBC_CODE_ROUTE : 8'h00);
         trip_code <= trip ? `DBC_CODE_TRIP : 8'h00;
         resistor_healthy_flag <= ~warn & ~trip;
         if (lim_on && (regen_reg < 16'sh0000 || regen_reg > $signed(avgp)))
            regen_limit <= avgp;
         else regen_limit <= regen_reg;
         regen_permitted <= unit_seen | ctrl.ext_unit;
      end
   end

   // ------------------------------------------------
   // Register readback
   // ------------------------------------------------
   // Read data, one cycle after the strobe
   // Zero outside the answer cycle
   // Status bits are live flags, not latched
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 32'h0;
      end else if (ce) begin
         reg_rdata <= 32'h0;
         if (reg_rd) begin
            case (reg_addr)
               `DBC_REG_CTRL: reg_rdata <= {24'h0, ctrl};
               `DBC_REG_THRESH: reg_rdata <= {16'h0, thresh};
               `DBC_REG_SCALE: reg_rdata <= {16'h0, scale};
               `DBC_REG_CEIL: reg_rdata <= {21'h0, ceil_mod};
               `DBC_REG_RAMP: reg_rdata <= {16'h0, ramp_ms};
               `DBC_REG_RES: reg_rdata <= {16'h0, res};
               `DBC_REG_AVGP: reg_rdata <= {16'h0, avgp};
               `DBC_REG_BUDGET: reg_rdata <= budget;
               `DBC_REG_REGEN: reg_rdata <= {16'h0, regen_reg};
               `DBC_REG_STATUS: reg_rdata <= {18'h0, active, unit_seen, route_warn, trip,
                                              warn, ~warn & ~trip, 1'b0, remaining};
               `DBC_REG_DEMAND: reg_rdata <= {5'h0, target, 5'h0, demand};
               `DBC_REG_VDC: reg_rdata <= {16'h0, vdc_q};
               `DBC_REG_CURR: reg_rdata <= i_01;
               `DBC_REG_POWER: reg_rdata <= p_01;
               default: reg_rdata <= 32'h0;
            endcase
         end
      end
   end
endmodule : dbc_brake
`default_nettype wire

// file: verif/dbc_link_model.sv
// Link voltage model: internal and percent-scaled measurements
`timescale 1ns/10ps
`default_nettype none
module dbc_link_model #(
   parameter int VOLTS_FULL = 1000
) (
   // Link level set by the bench
   input wire logic signed [15:0] link_volts,
   // Measurements toward the controller
   output logic signed [15:0] vdc_internal,
   output logic signed [15:0] analog_in1,
   output logic signed [15:0] analog_in2
);
   // Internal measurement in volts
   assign vdc_internal = link_volts;
   // Transducers report percent, 32768 = 100 percent
   assign analog_in1 = 16'(int'(link_volts) * 32768 / VOLTS_FULL);
   // Second channel wired with reversed polarity
   assign analog_in2 = 16'(-int'(link_volts) * 32768 / VOLTS_FULL);
endmodule : dbc_link_model
`default_nettype wire

// file: verif/dbc_brake_chk.sv
// Port assertions of the dynamic brake chopper controller
`timescale 1ns/10ps
`default_nettype none
module dbc_brake_chk #(
   parameter int unsigned SCAN_CYCLES = 50,
   parameter int unsigned PWM_CYCLES = 30,
   parameter logic [3:0] DB_METHOD = 4'h1
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic ce,
   // Register port
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Pins and outputs
   input wire dbc_pkg::dbc_pins_t pins,
   input wire logic brake_port_gate,
   input wire logic [2:0] bridge_gate,
   input wire logic [7:0] warn_code,
   input wire logic [7:0] trip_code,
   input wire logic resistor_healthy_flag,
   input wire logic regen_permitted
);
   logic [3:0] since_rst;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // Cycles since reset release, saturating
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn)
         since_rst <= 4'h0;
      else if (since_rst != 4'hF)
         since_rst <= since_rst + 4'h1;
   end
   chk_healthy_flag: assert property (resistor_healthy_flag == (warn_code != 8'h68 && trip_code != 8'h43))
      else $error("healthy flag disagrees with codes");
   chk_trip_code_set: assert property (trip_code inside {8'h00, 8'h43})
      else $error("unexpected trip code");
   chk_warn_code_set: assert property (warn_code inside {8'h00, 8'h68, 8'h8A})
      else $error("unexpected warning code");
   chk_trip_needs_warn: assert property (trip_code == 8'h43 |-> warn_code == 8'h68)
      else $error("trip without overload warning");
   chk_rdata_idle: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside answer cycle");
   chk_thermo_gates: assert property (pins.thermostat [*8] |-> !brake_port_gate && bridge_gate == 3'h0)
      else $error("gates driven under thermostat");
   chk_disabled_gates: assert property ((!pins.output_enabled && !pins.brake_enable) [*8] |-> !brake_port_gate && bridge_gate == 3'h0)
      else $error("gates driven while disabled");
   chk_port_bridge_excl: assert property (!(brake_port_gate && bridge_gate != 3'h0))
      else $error("port and bridge both driven");
   chk_unit_seen: assert property (since_rst == 4'hA && pins.mains_powerup |-> regen_permitted)
      else $error("unit not seen after mains power-up");
   // Main scenarios
   cover property ($rose(brake_port_gate));
   cover property (trip_code == 8'h43);
   cover property (bridge_gate[2]);
endmodule : dbc_brake_chk
bind dbc_brake dbc_brake_chk #(.SCAN_CYCLES(SCAN_CYCLES), .PWM_CYCLES(PWM_CYCLES),
   .DB_METHOD(DB_METHOD)) i_dbc_brake_chk (.sys_clk(sys_clk), .resetn(resetn), .ce(ce),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins), .brake_port_gate(brake_port_gate),
   .bridge_gate(bridge_gate), .warn_code(warn_code), .trip_code(trip_code),
   .resistor_healthy_flag(resistor_healthy_flag), .regen_permitted(regen_permitted));
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench of the dynamic brake chopper controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, rv, d1;
   dbc_pkg::dbc_pins_t pins = 5'b01000;
   logic signed [15:0] link_volts = 16'sh0320;
   logic signed [15:0] vdc_internal, analog_in1, analog_in2, regen_limit;
   logic [10:0] mod_ref = 11'h1F4;
   logic [3:0] motor_control_method = 4'h0;
   logic brake_port_gate, resistor_healthy_flag, regen_permitted;
   logic [2:0] bridge_gate;
   logic [7:0] warn_code, trip_code;
   int n_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #2.5 sys_clk = ~sys_clk;
   dbc_brake #(.SCAN_CYCLES(50), .PWM_CYCLES(30)) i_dbc_brake (.sys_clk(sys_clk),
      .resetn(resetn), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins), .vdc_internal(vdc_internal),
      .analog_in1(analog_in1), .analog_in2(analog_in2), .mod_ref(mod_ref),
      .motor_control_method(motor_control_method), .brake_port_gate(brake_port_gate),
      .bridge_gate(bridge_gate), .warn_code(warn_code), .trip_code(trip_code),
      .resistor_healthy_flag(resistor_healthy_flag), .regen_limit(regen_limit),
      .regen_permitted(regen_permitted));
   dbc_link_model i_dbc_link_model (.link_volts(link_volts), .vdc_internal(vdc_internal),
      .analog_in1(analog_in1), .analog_in2(analog_in2));
   task automatic conclude();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude
   // Cycle ceiling against hangs
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 10000) begin
         n_errors++;
         conclude();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd
   // High cycles of the port gate over one period
   task automatic count_high(output int n);
      n = 0;
      repeat (30) begin
         @(posedge sys_clk);
         #1;
         if (brake_port_gate === 1'b1)
            n++;
      end
   endtask : count_high
   task automatic wait_gate(input logic v);
      for (int i = 0; i < 60 && bridge_gate[0] !== v; i++) begin
         @(posedge sys_clk);
         #1;
      end
   endtask : wait_gate
   task automatic t_reset_values();
      rd(8'h00, rv);
      check(rv, 32'h05);
      rd(8'h24, rv);
      check(rv & 32'h1FFF, 32'h1164);
      rd(8'h30, rv);
      check(rv, 32'h0);
      rd(8'h3C, rv);
      check(rv, 32'h0);
   endtask : t_reset_values
   task automatic t_threshold();
      logic [1:0] src [4] = '{2'h1, 2'h2, 2'h3, 2'h2};
      int exp [4] = '{30, 30, 0, 0};
      int n;
      pins.output_enabled <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(8'h08, (i == 3) ? 32'h1F4 : 32'h3E8);
         wr(8'h00, {28'h0, src[i], 2'h1});
         cyc(120);
         count_high(n);
         check(n, exp[i]);
      end
      wr(8'h08, 32'h3E8);
      wr(8'h00, 32'h05);
      link_volts <= 16'sh02BC;
      cyc(120);
      rd(8'h2C, rv);
      check(rv & 32'hFFFF, 32'h2BC);
      count_high(n);
      check(n, 0);
      link_volts <= 16'sh0320;
      wr(8'h00, 32'h85);
      cyc(70);
      count_high(n);
      check(n, 0);
      pins.brake_enable <= 1'b1;
      cyc(70);
      count_high(n);
      check(n, 30);
      pins.brake_enable <= 1'b0;
   endtask : t_threshold
   task automatic t_prop();
      int n;
      wr(8'h10, 32'h0);
      wr(8'h0C, 32'h12C);
      wr(8'h00, 32'h15);
      cyc(150);
      rd(8'h28, rv);
      check(rv & 32'h7FF, 32'h12C);
      count_high(n);
      check(n, 9);
      wr(8'h10, 32'h3E8);
      wr(8'h0C, 32'h3E8);
      cyc(100);
      rd(8'h28, rv);
      cyc(48);
      rd(8'h28, d1);
      check(d1 - rv, 32'h5);
      pins.output_enabled <= 1'b0;
      cyc(10);
      rd(8'h28, rv);
      check(rv & 32'h7FF, 32'h0);
      check(brake_port_gate, 1'b0);
   endtask : t_prop
   task automatic t_overload();
      pins.output_enabled <= 1'b1;
      pins.thermostat <= 1'b1;
      for (int a = 0; a < 4; a++) begin
         wr(8'h00, 32'h4 | a);
         cyc(10);
         check(warn_code, (a > 0) ? 32'h68 : 32'h0);
         check(trip_code, (a > 1) ? 32'h43 : 32'h0);
         check(resistor_healthy_flag, a == 0);
         check({16'h0, regen_limit}, (a == 3) ? 32'h64 : 32'hFFFF);
      end
      rd(8'h24, rv);
      check(rv & 32'h7F, 32'h0);
      check(brake_port_gate, 1'b0);
      motor_control_method <= 4'h1;
      wr(8'h00, 32'h37);
      cyc(10);
      check({16'h0, regen_limit}, 32'hFFFF);
      check(trip_code, 32'h43);
      motor_control_method <= 4'h0;
      wr(8'h00, 32'h46);
      cyc(10);
      check(trip_code, 32'h0);
      check(regen_permitted, 1'b1);
      pins.thermostat <= 1'b0;
   endtask : t_overload
   task automatic t_bridge();
      int n;
      logic p;
      motor_control_method <= 4'h1;
      wr(8'h10, 32'h0);
      wr(8'h00, 32'h35);
      cyc(150);
      check(warn_code, 32'h8A);
      check(brake_port_gate, 1'b0);
      wait_gate(1'b0);
      wait_gate(1'b1);
      p = bridge_gate[1];
      for (n = 1; n < 30; n++) begin
         @(posedge sys_clk);
         #1;
         if (bridge_gate[1] === 1'b1 && p === 1'b0)
            break;
         p = bridge_gate[1];
      end
      check((n == 10) || (n == 20), 1'b1);
      motor_control_method <= 4'h0;
      cyc(10);
      check(warn_code, 32'h0);
      check(bridge_gate, 32'h0);
   endtask : t_bridge
   initial begin
      cyc(3);
      resetn <= 1'b1;
      cyc(6);
      t_reset_values();
      t_threshold();
      t_prop();
      t_overload();
      t_bridge();
      conclude();
   end
endmodule : testbench
`default_nettype wire
